// >>> shared/sbc_irq_pkg.sv
/*
  Constants shared by the interrupt unit of the system basis chip: register
  indexes, flag bit positions, timing figures and the interrupt pin states.
  Assumes a 200 MHz clock derived from the chip's internal oscillator.
*/
package sbc_irq_pkg;

  // ----------------------------------------------------------------------
  // register indexes of the serial read-only access
  // ----------------------------------------------------------------------
  localparam logic [2:0] WAKE_AND_SUMMARY_FLAGS = 3'h0;
  localparam logic [2:0] FAILURE_FLAGS_A        = 3'h1;
  localparam logic [2:0] FAILURE_FLAGS_B        = 3'h2;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  // wake_and_summary_flags
  localparam int CAN_WAKE_BIT      = 0;
  localparam int LIN_WAKE_BIT      = 1;
  localparam int WAKE_PIN_BIT      = 2;
  localparam int PERIODIC_WAKE_BIT = 3;
  localparam int SUMMARY_BIT       = 7;
  // failure_flags_a (state type)
  localparam int RAIL2_OVERTEMP_BIT  = 0;
  localparam int MCU_PREWARN_BIT     = 1;
  localparam int XCVR_OVERTEMP_BIT   = 2;
  localparam int CAN_FAIL_BIT        = 3;
  localparam int LIN_FAIL_BIT        = 4;
  localparam int RAIL3_OVERCUR_BIT   = 5;
  localparam int RAIL2_UNDERVOLT_BIT = 6;
  localparam int RAIL3_UNDERVOLT_BIT = 7;
  // failure_flags_b (event type)
  localparam int SPI_FAIL_BIT      = 0;
  localparam int RESET_EVENT_BIT   = 1;
  localparam int BAD_WD_CONFIG_BIT = 2;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [3:0] WAKE_FLAGS_RESET = 4'h0;
  localparam logic [7:0] FAIL_A_RESET     = 8'h00;
  localparam logic [2:0] FAIL_B_RESET     = 3'h0;
  localparam logic [7:0] ACK_A_RESET      = 8'hFF;
  localparam logic [7:0] READ_DATA_RESET  = 8'h00;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLOCK_PERIOD_PS     = 5000;
  localparam int IRQ_TIMEOUT_US      = 6000;
  localparam int IRQ_MIN_PULSE_US    = 10;
  // split so the product stays inside a 32-bit int
  localparam int IRQ_TIMEOUT_CYCLES  = IRQ_TIMEOUT_US * (1000000 / CLOCK_PERIOD_PS);
  localparam int IRQ_MIN_PULSE_CYCLES =
    (IRQ_MIN_PULSE_US * 1000000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int COUNT_WIDTH         = 21;

  typedef enum logic [1:0] {IRQ_IDLE, IRQ_ACTIVE, IRQ_GAP} irq_state_t;

endpackage : sbc_irq_pkg

// >>> rtl/sbc_edge_detect.sv
/*
  Rising and falling edge detector for a group of condition levels.
  Assumes the levels are synchronous to the clock.
*/
`timescale 1ns/100ps
module sbc_edge_detect #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  typedef struct packed {
    logic [WIDTH-1:0] previous;
  } edge_state_t;

  edge_state_t s;
  edge_state_t next_s;

  always_comb begin
    next_s.previous = level;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rise = level & ~s.previous;
  assign fall = ~level & s.previous;

endmodule : sbc_edge_detect

// >>> rtl/sbc_interrupt_unit.sv
/*
  Interrupt unit: collects wake, temperature, communication, regulator and
  chip failure events into three flag registers and drives the active-low
  open-drain interrupt pin toward the microcontroller.
  Assumes a serial front end that delivers one-cycle read-only strobes with a
  register index, and source levels/pulses synchronous to the clock.
*/
`timescale 1ns/100ps
// Operation
// - unmasked source events pull the interrupt pin low
// - masked source sets flag but no pin
// - rail undervoltage interrupts on both edges
// - state flags latch, then follow live condition
// - chip failure and wake flags are events
// - pin released by read of 000 or timeout
// - wake flags read and cleared in 000
// - summary bit flags non-wake sources in 000
// - read clears events, persisting states stay set
// - summary clears only when all failure flags clear
// - sample pin in init for configuration select
// - no undervoltage interrupt while rail off
// - rail switch-on sets flag and interrupts
// - read keeps switch-on flag while undervoltage persists
// - second interrupt when rail leaves undervoltage
// - reset source only in software development mode
// - pin low at most irq_timeout
// - pin low at least irq_min_pulse
// - several sources before read, one pulse
// - irq_timeout gap between pulses, late events stored
module sbc_interrupt_unit
  import sbc_irq_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = IRQ_TIMEOUT_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       readStrobe,
  input  wire logic [2:0] readAddr,
  output logic      [7:0] readData,
  input  wire logic [3:0] wakeEvent,
  input  wire logic [7:0] failCondition,
  input  wire logic [2:0] failEvent,
  input  wire logic [1:0] railOn,
  input  wire logic [1:0] railSwitchOn,
  input  wire logic [3:0] wakeMask,
  input  wire logic [7:0] failMaskA,
  input  wire logic [2:0] failMaskB,
  input  wire logic       softwareDevMode,
  input  wire logic       initMode,
  input  wire logic       reset_out_n,
  input  wire logic       irqPinIn,
  output logic            irqPinOut,
  output logic            irqPinOe,
  output logic            configSel
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0]             wakeFlags;
    logic [7:0]             failA;
    logic [7:0]             ackA;
    logic [2:0]             failB;
    irq_state_t             st;
    logic [COUNT_WIDTH-1:0] cnt;
    logic                   pending;
    logic                   readSeen;
    logic [7:0]             rdData;
    logic                   irqOe;
    logic                   configSel;
    logic                   pinLow;
  } unit_state_t;

  unit_state_t s;
  unit_state_t next_s;

  function automatic logic [COUNT_WIDTH-1:0] cycles(input int n);
    return COUNT_WIDTH'(n);
  endfunction : cycles

  // ----------------------------------------------------------------------
  // source conditioning
  // ----------------------------------------------------------------------
  logic [7:0] liveA;
  logic [7:0] condRise;
  logic [7:0] condFall;
  logic [7:0] setA;
  logic [2:0] setB;
  logic       readZero;
  logic       readA;
  logic       readB;
  logic       anyUnmasked;
  logic       summary;
  logic [1:0] uvFall;

  always_comb begin
    liveA = failCondition;
    // an undervoltage on a switched-off rail is not a fault
    liveA[RAIL2_UNDERVOLT_BIT] = failCondition[RAIL2_UNDERVOLT_BIT] & railOn[0];
    liveA[RAIL3_UNDERVOLT_BIT] = failCondition[RAIL3_UNDERVOLT_BIT] & railOn[1];
  end

  sbc_edge_detect #(.WIDTH(8)) u_edges (
    .clock (clock),
    .rst   (rst),
    .level (liveA),
    .rise  (condRise),
    .fall  (condFall)
  );

  always_comb begin
    setA = condRise;
    uvFall = {condFall[RAIL3_UNDERVOLT_BIT] & railOn[1],
              condFall[RAIL2_UNDERVOLT_BIT] & railOn[0]};
    setA[RAIL2_UNDERVOLT_BIT] = condRise[RAIL2_UNDERVOLT_BIT] | uvFall[0]
                                | railSwitchOn[0];
    setA[RAIL3_UNDERVOLT_BIT] = condRise[RAIL3_UNDERVOLT_BIT] | uvFall[1]
                                | railSwitchOn[1];
    setB = failEvent;
    setB[RESET_EVENT_BIT] = failEvent[RESET_EVENT_BIT] & softwareDevMode;
    readZero = readStrobe && readAddr == WAKE_AND_SUMMARY_FLAGS;
    readA    = readStrobe && readAddr == FAILURE_FLAGS_A;
    readB    = readStrobe && readAddr == FAILURE_FLAGS_B;
    anyUnmasked = |(wakeEvent & wakeMask) | |(setA & failMaskA) | |(setB & failMaskB);
    summary = |s.failA | |s.failB;
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.pinLow = 1'b0;

    // wake and chip failure flags: pure events, a read empties them
    // but a set in the same cycle survives
    next_s.wakeFlags = (readZero ? 4'h0 : s.wakeFlags) | wakeEvent;
    next_s.failB     = (readB ? 3'h0 : s.failB) | setB;

    // state flags: latched until read, afterwards they track the live level
    for (int i = 0; i < 8; i++) begin
      if (setA[i]) begin
        next_s.failA[i] = 1'b1;
        next_s.ackA[i]  = 1'b0;
      end else if (readA || s.ackA[i]) begin
        next_s.failA[i] = liveA[i];
        next_s.ackA[i]  = 1'b1;
      end
    end

    // read data is captured before the read side effect lands
    if (readStrobe) begin
      unique case (readAddr)
        WAKE_AND_SUMMARY_FLAGS: next_s.rdData = {summary, 3'h0, s.wakeFlags};
        FAILURE_FLAGS_A:        next_s.rdData = s.failA;
        FAILURE_FLAGS_B:        next_s.rdData = {5'h00, s.failB};
        default:                next_s.rdData = READ_DATA_RESET;
      endcase
    end

    // configuration strap is read while the pin is not driven
    if (initMode && !reset_out_n) begin
      next_s.configSel = irqPinIn;
    end

    // pin sequencer; counts oscillator-derived clock cycles
    next_s.cnt = s.cnt + cycles(1);
    unique case (s.st)
      IRQ_IDLE: begin
        next_s.cnt = '0;
        if ((s.pending || anyUnmasked) && !initMode) begin
          next_s.st       = IRQ_ACTIVE;
          next_s.irqOe    = 1'b1;
          next_s.pending  = 1'b0;
          next_s.readSeen = readZero;
        end else begin
          next_s.pending = s.pending | anyUnmasked;
        end
      end
      IRQ_ACTIVE: begin
        // further sources merge into this pulse; the flags keep them
        next_s.readSeen = s.readSeen | readZero;
        if ((next_s.readSeen && s.cnt >= cycles(IRQ_MIN_PULSE_CYCLES - 1))
            || s.cnt >= cycles(TIMEOUT_CYCLES - 1)) begin
          next_s.st    = IRQ_GAP;
          next_s.irqOe = 1'b0;
          next_s.cnt   = '0;
        end
      end
      IRQ_GAP: begin
        next_s.pending = s.pending | anyUnmasked;
        if (s.cnt >= cycles(TIMEOUT_CYCLES - 1)) begin
          next_s.st  = IRQ_IDLE;
          next_s.cnt = '0;
        end
      end
      default: begin
        next_s.st = IRQ_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      s.wakeFlags <= WAKE_FLAGS_RESET;
      s.failA     <= FAIL_A_RESET;
      s.ackA      <= ACK_A_RESET;
      s.failB     <= FAIL_B_RESET;
      s.st        <= IRQ_IDLE;
      s.cnt       <= '0;
      s.pending   <= 1'b0;
      s.readSeen  <= 1'b0;
      s.rdData    <= READ_DATA_RESET;
      s.irqOe     <= 1'b0;
      s.configSel <= 1'b0;
      s.pinLow    <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // open drain: the output level is always low, only the enable moves
  assign readData  = s.rdData;
  assign irqPinOe  = s.irqOe;
  assign irqPinOut = s.pinLow;
  assign configSel = s.configSel;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  sequence pulseStart;
    !s.irqOe ##1 s.irqOe;
  endsequence

  sequence pulseEnd;
    s.irqOe ##1 !s.irqOe;
  endsequence

  AST_IRQ_ON_EVENT: assert property (
    @(posedge clock) disable iff (rst)
    s.st == IRQ_IDLE && anyUnmasked && !initMode |=> s.irqOe
  ) else $error("unmasked event did not pull the pin low");

  AST_MASKED_SILENT: assert property (
    @(posedge clock) disable iff (rst)
    s.st == IRQ_IDLE && !s.pending && !anyUnmasked |=> !s.irqOe
  ) else $error("pin asserted without an unmasked source");

  AST_UV_FALL_FLAG: assert property (
    @(posedge clock) disable iff (rst)
    uvFall[0] |=> s.failA[RAIL2_UNDERVOLT_BIT] && !s.ackA[RAIL2_UNDERVOLT_BIT]
  ) else $error("undervoltage release was not latched");

  AST_STATE_LATCHED: assert property (
    @(posedge clock) disable iff (rst)
    !readA |=> ($past(s.failA & ~s.ackA) & ~s.failA) == 8'h00
  ) else $error("latched state flag lost before read");

  AST_WAKE_CLEARED: assert property (
    @(posedge clock) disable iff (rst)
    readZero && wakeEvent == 4'h0 |=> s.wakeFlags == 4'h0
  ) else $error("wake flags survived a read");

  AST_SUMMARY_READ: assert property (
    @(posedge clock) disable iff (rst)
    readZero |=> s.rdData[SUMMARY_BIT] == ($past(s.failA) != 8'h00 || $past(s.failB) != 3'h0)
  ) else $error("summary bit does not match failure flags");

  AST_SWITCH_ON_FLAG: assert property (
    @(posedge clock) disable iff (rst)
    railSwitchOn[1] |=> s.failA[RAIL3_UNDERVOLT_BIT]
  ) else $error("switch-on did not set the undervoltage flag");

  AST_TIMEOUT_BOUND: assert property (
    @(posedge clock) disable iff (rst)
    s.irqOe |-> s.cnt < cycles(TIMEOUT_CYCLES)
  ) else $error("pin held low beyond the time-out");

  AST_MIN_PULSE: assert property (
    @(posedge clock) disable iff (rst)
    pulseStart |-> s.irqOe [*8]
  ) else $error("pin pulse shorter than its minimum");

  AST_GAP_HELD: assert property (
    @(posedge clock) disable iff (rst)
    pulseEnd |-> !s.irqOe [*8]
  ) else $error("pin reasserted inside the gap");

  AST_WAKE_SET_MASKED: assert property (
    @(posedge clock) disable iff (rst)
    wakeEvent != 4'h0 |=> (s.wakeFlags & $past(wakeEvent)) == $past(wakeEvent)
  ) else $error("wake event not recorded in its flag");

  AST_STATE_FOLLOWS: assert property (
    @(posedge clock) disable iff (rst)
    readA && setA == 8'h00 |=> s.failA == $past(liveA)
  ) else $error("state flags do not follow the live condition after read");

  AST_RELEASE_ON_READ: assert property (
    @(posedge clock) disable iff (rst)
    s.st == IRQ_ACTIVE && (s.readSeen || readZero)
      && s.cnt >= cycles(IRQ_MIN_PULSE_CYCLES - 1) |=> !s.irqOe
  ) else $error("pin not released after read of the wake register");

  AST_EVENT_CLEARED: assert property (
    @(posedge clock) disable iff (rst)
    readB && setB == 3'h0 |=> s.failB == 3'h0
  ) else $error("event flags survived a read");

  AST_CONFIG_SAMPLE: assert property (
    @(posedge clock) disable iff (rst)
    initMode && !reset_out_n |=> s.configSel == $past(irqPinIn)
  ) else $error("configuration not taken from the pin");

  AST_CONFIG_HOLD: assert property (
    @(posedge clock) disable iff (rst)
    !initMode || reset_out_n |=> $stable(s.configSel)
  ) else $error("configuration changed outside init");

  AST_RAIL_OFF_QUIET: assert property (
    @(posedge clock) disable iff (rst)
    !railOn[1] && !railSwitchOn[1] |-> !setA[RAIL3_UNDERVOLT_BIT]
  ) else $error("undervoltage raised on a switched-off rail");

  AST_RESET_SOURCE_OFF: assert property (
    @(posedge clock) disable iff (rst)
    !softwareDevMode && !s.failB[RESET_EVENT_BIT] |=> !s.failB[RESET_EVENT_BIT]
  ) else $error("reset source flagged outside development mode");

  AST_MIN_PULSE_LEN: assert property (
    @(posedge clock) disable iff (rst)
    pulseEnd |-> $past(s.cnt) >= cycles(IRQ_MIN_PULSE_CYCLES - 1)
  ) else $error("pin released before its minimum width");

  AST_MERGE_ONE_PULSE: assert property (
    @(posedge clock) disable iff (rst)
    s.st == IRQ_ACTIVE |=> !s.pending
  ) else $error("event during a pulse queued another pulse");

  AST_GAP_STORED: assert property (
    @(posedge clock) disable iff (rst)
    s.st == IRQ_GAP && anyUnmasked |=> s.pending
  ) else $error("event inside the gap was not stored");

endmodule : sbc_interrupt_unit

// >>> verif/sbc_host_model.sv
/*
  Host side of the interrupt pin: pull resistors and the configuration strap.
  Assumes the unit pulls the pin low only while its enable is high.
*/
`timescale 1ns/100ps
module sbc_host_model (
  input  wire logic pinOe,
  input  wire logic pinOut,
  input  wire logic strapPhase,
  input  wire logic strapLevel,
  output logic      pinLevel
);
  // ----------------------------------------------------------------------
  // wired pin
  // ----------------------------------------------------------------------
  // the strap only counts while the unit samples it; otherwise the pull-up wins
  assign pinLevel = pinOe ? pinOut : (strapPhase ? strapLevel : 1'b1);
endmodule : sbc_host_model

// >>> verif/tb_sbc_interrupt_unit.sv
/*
  Self-checking bench of the interrupt unit with random sources and reads.
  Assumes a 200 MHz clock and a shortened time-out above the minimum pulse.
*/
`timescale 1ns/100ps
module tb_sbc_interrupt_unit;
  import sbc_irq_pkg::*;
  localparam int TO = 3000;
  localparam int MP = IRQ_MIN_PULSE_CYCLES;
  logic        clock = 1'b0, rst = 1'b1, readStrobe = 1'b0, softwareDevMode = 1'b0;
  logic        initMode = 1'b0, reset_out_n = 1'b1, strapLevel = 1'b1;
  logic        irqPinIn, irqPinOut, irqPinOe, configSel;
  logic [2:0]  readAddr = 3'h0, failEvent = 3'h0, failMaskB = 3'h0;
  logic [7:0]  readData, failCondition = 8'h00, failMaskA = 8'h00;
  logic [3:0]  wakeEvent = 4'h0, wakeMask = 4'h0;
  logic [1:0]  railOn = 2'h3, railSwitchOn = 2'h0;
  logic [31:0] seed = 32'h5ddd_e683;
  int          fails = 0, total_checks = 0, n, b, hiRun = 0, loRun = 0;
  int          pulseLen = 0, gapLen = 0, pulses = 0, p0;

  always #2.5 clock = ~clock;

  sbc_interrupt_unit #(.TIMEOUT_CYCLES(TO)) DUT (
    .clock(clock), .rst(rst), .readStrobe(readStrobe), .readAddr(readAddr),
    .readData(readData), .wakeEvent(wakeEvent), .failCondition(failCondition),
    .failEvent(failEvent), .railOn(railOn), .railSwitchOn(railSwitchOn),
    .wakeMask(wakeMask), .failMaskA(failMaskA), .failMaskB(failMaskB),
    .softwareDevMode(softwareDevMode), .initMode(initMode), .reset_out_n(reset_out_n),
    .irqPinIn(irqPinIn), .irqPinOut(irqPinOut), .irqPinOe(irqPinOe), .configSel(configSel));

  sbc_host_model host (.pinOe(irqPinOe), .pinOut(irqPinOut),
    .strapPhase(initMode & ~reset_out_n), .strapLevel(strapLevel), .pinLevel(irqPinIn));

  // ----------------------------------------------------------------------
  // pin pulse and gap lengths, counted in clock cycles
  // ----------------------------------------------------------------------
  always @(posedge clock) begin
    if (irqPinOe === 1'b1) begin
      if (hiRun == 0) begin
        gapLen = loRun;
        pulses++;
      end
      hiRun++;
      loRun = 0;
    end else begin
      if (hiRun != 0) pulseLen = hiRun;
      loRun++;
      hiRun = 0;
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  function automatic logic [7:0] reg0Exp(input logic sum, input logic [3:0] wk);
    return {sum, 3'h0, wk};
  endfunction : reg0Exp

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
    @(posedge clock);
    readStrobe <= 1'b1;
    readAddr   <= a;
    @(posedge clock);
    readStrobe <= 1'b0;
    // the answer stands from the edge after the strobe until the next strobe
    @(posedge clock);
    check(what, exp, readData);
  endtask : rd

  task automatic pulse(input logic [3:0] wk, input logic [2:0] fe, input logic [1:0] so);
    @(posedge clock);
    wakeEvent    <= wk;
    failEvent    <= fe;
    railSwitchOn <= so;
    @(posedge clock);
    wakeEvent    <= 4'h0;
    failEvent    <= 3'h0;
    railSwitchOn <= 2'h0;
    repeat (3) @(posedge clock);
  endtask : pulse

  // a wait that runs out of its bound ends the run as a mismatch
  task automatic waitOe(input logic lvl, input int bound);
    n = 0;
    while (irqPinOe !== lvl) begin
      @(posedge clock);
      #1 n++;
      if (n > bound) begin
        fails++;
        $display("Error irqPinOe expected %b seen %b", lvl, irqPinOe);
        give_verdict();
      end
    end
    // one more edge so the pulse monitor has logged the change just seen
    @(posedge clock);
    #1;
  endtask : waitOe

  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    for (int a = 0; a < 6; a++) rd(3'(a), 8'h00, "reset read");
    check("reset pin", 1'b0, irqPinOe);
    initMode    <= 1'b1;
    reset_out_n <= 1'b0;
    for (int v = 1; v >= 0; v--) begin
      strapLevel <= v[0];
      repeat (3) @(posedge clock);
      check("configSel", v[0], configSel);
    end
    initMode    <= 1'b0;
    reset_out_n <= 1'b1;
    repeat (3) @(posedge clock);
    check("configSel hold", 1'b0, configSel);
    seed = xs(seed);
    b = seed[1:0];
    pulse(4'h1 << b, 3'h0, 2'h0);
    check("masked pin", 1'b0, irqPinOe);
    rd(3'h0, reg0Exp(1'b0, 4'h1 << b), "wake flag");
    rd(3'h0, 8'h00, "wake cleared");
    for (int k = 0; k < 2; k++) begin
      seed = xs(seed);
      b = k ? 6 : seed[2:0];
      failCondition <= 8'h01 << b;
      repeat (3) @(posedge clock);
      rd(3'h0, 8'h80, "summary");
      rd(3'h1, 8'h01 << b, "state flag");
      rd(3'h1, 8'h01 << b, "state persists");
      rd(3'h0, 8'h80, "summary held");
      failCondition <= 8'h00;
      repeat (3) @(posedge clock);
      rd(3'h1, (b >= 6) ? 8'h01 << b : 8'h00, "falling edge");
      rd(3'h1, 8'h00, "live state");
      rd(3'h0, 8'h00, "summary clear");
    end
    pulse(4'h0, 3'h0, 2'h1);
    rd(3'h1, 8'h40, "switch-on flag");
    rd(3'h1, 8'h00, "switch-on cleared");
    railOn        <= 2'h1;
    failCondition <= 8'h80;
    repeat (3) @(posedge clock);
    rd(3'h1, 8'h00, "rail off");
    railOn <= 2'h3;
    pulse(4'h0, 3'h0, 2'h2);
    rd(3'h1, 8'h80, "short switch-on");
    rd(3'h1, 8'h80, "short kept");
    failCondition <= 8'h00;
    repeat (3) @(posedge clock);
    rd(3'h1, 8'h80, "leave undervolt");
    rd(3'h1, 8'h00, "rail clean");
    pulse(4'h0, 3'h2, 2'h0);
    rd(3'h2, 8'h00, "reset source off");
    softwareDevMode <= 1'b1;
    for (int e = 0; e < 3; e++) begin
      pulse(4'h0, 3'h1 << e, 2'h0);
      rd(3'h2, 8'h01 << e, "event flag");
      rd(3'h2, 8'h00, "event cleared");
    end
    rd(3'h0, 8'h00, "summary idle");
    check("no pin while masked", 0, pulses);
    wakeMask  <= 4'hF;
    failMaskB <= 3'h7;
    failMaskA <= 8'hFF;
    seed = xs(seed);
    b = seed[1:0];
    pulse(4'h1 << b, 3'h0, 2'h0);
    waitOe(1'b1, 2);
    check("pin low", 1'b0, irqPinIn);
    pulse(4'h8, 3'h0, 2'h0);
    rd(3'h0, reg0Exp(1'b0, (4'h1 << b) | 4'h8), "merged flags");
    waitOe(1'b0, MP + 10);
    check("min pulse", 1'b1, pulseLen inside {[MP:MP + 2]});
    p0 = pulses;
    repeat (TO + 20) @(posedge clock);
    check("one pulse", p0, pulses);
    pulse(4'h1, 3'h0, 2'h0);
    waitOe(1'b0, TO + 10);
    check("timeout", 1'b1, pulseLen inside {[TO - 1:TO + 1]});
    rd(3'h0, 8'h01, "flag after timeout");
    pulse(4'h0, 3'h1, 2'h0);
    waitOe(1'b1, TO + 10);
    check("gap", 1'b1, gapLen inside {[TO - 1:TO + 2]});
    rd(3'h0, 8'h80, "summary pin");
    rd(3'h2, 8'h01, "stored event");
    waitOe(1'b0, TO + 10);
    check("read release", 1'b1, pulseLen inside {[MP:MP + 40]});
    give_verdict();
  end
endmodule : tb_sbc_interrupt_unit
